//--- verification/ots_drv_model.sv
// far side of the supervisor pins: driver ICs on the PWM lines, pull-ups on the flags
// assumes pwm_oe high while a PWM line is driven, flag oe high while the pin is pulled low
`timescale 1ns/1ps
module ots_drv_model
  import ots_pkg::*;
(
  input wire logic [NPH-1:0] pwm_o,
  input wire logic [NPH-1:0] pwm_oe,
  input wire logic cool_o,
  input wire logic cool_oe,
  input wire logic hot_o,
  input wire logic hot_oe,
  output logic [NPH-1:0] fets_off,
  output logic [NPH-1:0] low_fet_on,
  output logic cool_pin,
  output logic hot_pin
);
  // a floating PWM input turns both transistors off
  assign fets_off = ~pwm_oe;
  assign low_fet_on = pwm_oe & ~pwm_o;
  // pull-up wins whenever the pin is released
  assign cool_pin = cool_oe ? cool_o : 1'b1;
  assign hot_pin = hot_oe ? hot_o : 1'b1;
endmodule // ots_drv_model

//--- verification/tb_ots_supervisor.sv
// self-checking bench for the supervisor: AXI4-Lite master, comparator and ratio stimulus
// assumes the driver/pull-up model beside it; cycle_start is made by the bench
`timescale 1ns/1ps
module tb_ots_supervisor;
  import ots_pkg::*;
  // trip edge, 4096 counted pulses, restart edge, one more edge to observe it
  localparam int HIC_LAT = 4099;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ss, cool_o, cool_oe, hot_o, hot_oe;
  logic [1:0] bresp, rresp, r;
  logic en = 1'b0, cyc = 1'b0, avg = 1'b0, mon = 1'b0;
  logic [3:0] ph_cmp = 4'h0, pwm_req = 4'h0, pwm_o, pwm_oe, fets_off, low_on, factor, req, m;
  logic [9:0] tm = 10'h3ff, toff = 10'h000;
  logic [5:0] temp_code;
  logic [11:0] gain;
  logic cool_pin, hot_pin;
  logic [31:0] d;
  int bad_count = 0, samples_checked = 0, seed = 32'hf4a576f4;
  int i, lvl, off, tc, f, g, t, cool = 1, hot = 1;
  int lv[8] = '{'h18f, 'h190, 'h191, 'h1cd, 'h1cf, 'h154, 'h155, 'h156};

  always #20 aclk = ~aclk;

  ots_supervisor DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ctrl_enable(en),
    .cycle_start(cyc), .averaged_phase_current_ovr(avg), .load_current_monitor_pin_ovr(mon),
    .phase_oc_cmp(ph_cmp), .pwm_req(pwm_req), .thermistor_sense_input(tm),
    .thermal_offset_input(toff), .pwm_o(pwm_o), .pwm_oe(pwm_oe),
    .cooling_request_o(cool_o), .cooling_request_oe(cool_oe), .overtemp_alert_o(hot_o),
    .overtemp_alert_oe(hot_oe), .soft_start_req(ss), .temp_code(temp_code),
    .thermal_offset_input_factor(factor), .comp_gain(gain));

  ots_drv_model PTN (.pwm_o(pwm_o), .pwm_oe(pwm_oe), .cool_o(cool_o), .cool_oe(cool_oe),
    .hot_o(hot_o), .hot_oe(hot_oe), .fets_off(fets_off), .low_fet_on(low_on),
    .cool_pin(cool_pin), .hot_pin(hot_pin));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic lost(input int n, input int lim);
    if (n >= lim) begin
      bad_count++;
      give_verdict();
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    lost(n, 20);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    lost(n, 20);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // counts edges from the causing edge until the soft-start pulse is seen
  task automatic to_ss(input int n0, input int exp_n);
    int n;
    logic leak;
    n = n0;
    leak = 1'b0;
    while (n < 5000) begin
      @(posedge aclk);
      avg <= 1'b0;
      n++;
      if (ss === 1'b1) break;
      if (n >= 2 && pwm_oe !== 4'h0) leak = 1'b1;
    end
    lost(n, 5000);
    chk(n, exp_n);
    chk(leak, 1'b0);
    chk(pwm_oe, 4'hf);
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axr(ADDR_CTRL, d, r);
    chk(d, 32'h1);
    axr(ADDR_THERM, d, r);
    chk(d, 32'h0400_0000);
    axr(8'h10, d, r);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    axw(8'h10, 32'h0, r);
    chk(r, RESP_SLVERR);
    chk({fets_off, cool_oe, hot_oe}, 6'h3f);
    @(posedge aclk);
    en <= 1'b1;
    to_ss(0, 2);
    // per-phase cut with random modulator levels
    for (i = 0; i < NPH; i++) begin
      @(posedge aclk);
      req = 4'($random(seed));
      m = 4'h1 << i;
      pwm_req <= req;
      ph_cmp <= m;
      @(posedge aclk);
      ph_cmp <= 4'h0;
      @(posedge aclk);
      chk(pwm_o, req & ~m);
      chk(low_on, 4'(~(req & ~m)));
      axr(ADDR_STATUS, d, r);
      chk({d[11:8], d[1:0]}, {m, 2'h1});
      chk(pwm_o, req & ~m);
      @(posedge aclk);
      cyc <= 1'b1;
      @(posedge aclk);
      cyc <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(pwm_o, req);
    end
    axr(ADDR_TRIP_CNT, d, r);
    chk(d, 32'h0);
    // thermal flags and compensation gain against the ratio model
    for (i = 0; i < 32; i++) begin
      @(posedge aclk);
      t = $unsigned($random(seed)) % 9;
      lvl = (t == 8) ? ($unsigned($random(seed)) % 1024) : lv[t];
      off = (i % 4 == 0) ? 0 : ($unsigned($random(seed)) % 1024);
      tm <= 10'(lvl);
      toff <= 10'(off);
      repeat (4) @(posedge aclk);
      if (lvl > 'h1ce) cool = 1; else if (lvl < 'h190) cool = 0;
      if (lvl > 'h190) hot = 1; else if (lvl < 'h155) hot = 0;
      tc = ('h3ff - lvl) >> 4;
      f = (off * 15) >> 10;
      t = (tc + f - 4 < 0) ? 0 : tc + f - 4;
      g = (f == 0) ? 'h400 : 'h400 - 4 * t;
      chk({cool_oe, cool_pin}, {cool[0], ~cool[0]});
      chk({hot_oe, hot_pin}, {hot[0], ~hot[0]});
      chk({temp_code, factor, gain}, {6'(tc), 4'(f), 12'(g)});
    end
    axr(ADDR_THERM, d, r);
    chk(d, (g << 16) | (f << 8) | tc);
    // trip, then disable in mid-wait
    cyc <= 1'b1;
    @(posedge aclk);
    avg <= 1'b1;
    @(posedge aclk);
    avg <= 1'b0;
    @(posedge aclk);
    chk({pwm_oe, fets_off}, 8'h0f);
    repeat (100) @(posedge aclk);
    axw(ADDR_CTRL, 32'h0, r);
    axr(ADDR_STATUS, d, r);
    chk({d[6], d[1:0], cool_oe, hot_oe}, 5'h03);
    axw(ADDR_CTRL, 32'h1, r);
    axr(ADDR_STATUS, d, r);
    chk(d[1:0], 2'h1);
    // full hiccup, count starts from zero again
    @(posedge aclk);
    avg <= 1'b1;
    to_ss(0, HIC_LAT);
    @(posedge aclk);
    mon <= 1'b1;
    to_ss(0, HIC_LAT);
    to_ss(1, HIC_LAT);
    @(posedge aclk);
    mon <= 1'b0;
    en <= 1'b0;
    repeat (3) @(posedge aclk);
    axr(ADDR_TRIP_CNT, d, r);
    chk(d, 32'h5);
    axr(ADDR_STATUS, d, r);
    chk(d[1:0], 2'h0);
    axw(ADDR_TRIP_CNT, 32'h0, r);
    axr(ADDR_TRIP_CNT, d, r);
    chk(d, 32'h0);
    give_verdict();
  end
endmodule // tb_ots_supervisor

//--- verilog/ots_hyst_flag.sv
// one open-drain thermal flag with hysteresis on the thermistor ratio
// assumes level is a synchronous sample; drive_low_q high means the pin is pulled low
`timescale 1ns/1ps
module ots_hyst_flag (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic valid,
  input wire logic [9:0] level,
  input wire logic [9:0] pull_th,
  input wire logic [9:0] release_th,
  output logic drive_low_q
);
  // a falling ratio means a hotter part: release the pin to signal heat
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_low_q <= 1'b1;
    end else if (!valid) begin
      drive_low_q <= 1'b1;
    end else if (level > pull_th) begin
      drive_low_q <= 1'b1;
    end else if (level < release_th) begin
      drive_low_q <= 1'b0;
    end
  end
endmodule // ots_hyst_flag

//--- verilog/ots_pkg.sv
// constants, register map and state type for the overcurrent/thermal supervisor
// assumes one 25 MHz clock, comparator results and ratio samples arriving synchronously
// Summary of operation
// - average current above 105uA starts shutdown
// - monitor pin above 1.11V starts shutdown
// - shutdown floats all PWM outputs at once
// - outputs stay floating for 4096 switching cycles
// - retry soft-start only while still enabled
// - persisting fault repeats trip, wait, retry forever
// - phase over its limit: PWM low rest-of-cycle
// - cut phase may switch again next cycle
// - phase limit never causes shutdown or hiccup
// - thermal flags are open-drain, valid when enabled
// - cooling request: release below 39.1%, pull above 45.1%
// - overtemp alert: release below 33.3%, pull above 39.1%
// - thermistor ratio becomes 6-bit temperature code
// - offset ratio becomes 4-bit factor 0..14
// - factor zero disables temperature compensation
// - factor 4 means no temperature difference
// - factor and code form per-phase current gain (here one comp_gain is shared by all phases)
// - PWM outputs float while in shutdown
package ots_pkg;
  localparam int NPH = 4;
  localparam int CLK_PERIOD_NS = 40;
  localparam int OC_HIZ_MAX_NS = 20;
  // longest time rounds down, but never below one cycle
  localparam int OC_HIZ_CYC = (OC_HIZ_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 :
                              (OC_HIZ_MAX_NS / CLK_PERIOD_NS);
  localparam logic [12:0] HICCUP_CYCLES = 13'h1000;
  // thermistor and offset ratios are fractions of supply, full scale 10'h3ff
  localparam logic [9:0] TM_FAN_RELEASE = 10'h190;
  localparam logic [9:0] TM_FAN_PULL = 10'h1ce;
  localparam logic [9:0] TM_HOT_RELEASE = 10'h155;
  localparam logic [9:0] TM_HOT_PULL = 10'h190;
  localparam logic [3:0] THERMAL_OFFSET_INPUT_FACTOR_MULT = 4'hf;
  localparam logic [3:0] THERMAL_OFFSET_INPUT_ZERO_DELTA = 4'h4;
  localparam logic [11:0] GAIN_UNITY = 12'h400;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_THERM = 8'h08;
  localparam logic [7:0] ADDR_TRIP_CNT = 8'h0c;
  localparam int CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RESET = 1'b1;
  localparam int STS_STATE_LSB = 0;
  localparam int STS_AVG_OC_BIT = 2;
  localparam int STS_MON_OC_BIT = 3;
  localparam int STS_COOL_BIT = 4;
  localparam int STS_HOT_BIT = 5;
  localparam int STS_EN_BIT = 6;
  localparam int STS_BLANK_LSB = 8;
  localparam int THERM_TEMP_LSB = 0;
  localparam int THERM_FACTOR_LSB = 8;
  localparam int THERM_GAIN_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_WAIT} ots_state_t;
endpackage

//--- verilog/ots_supervisor.sv
// overcurrent hiccup, per-phase pulse cut, thermal flags and compensation gain
// assumes comparator inputs and ratio samples are synchronous to aclk,
// cycle_start pulses once per switching cycle, AXI4-Lite master on the bus
`timescale 1ns/1ps
module ots_supervisor
  import ots_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ctrl_enable,
  input wire logic cycle_start,
  input wire logic averaged_phase_current_ovr,
  input wire logic load_current_monitor_pin_ovr,
  input wire logic [NPH-1:0] phase_oc_cmp,
  input wire logic [NPH-1:0] pwm_req,
  input wire logic [9:0] thermistor_sense_input,
  input wire logic [9:0] thermal_offset_input,
  output logic [NPH-1:0] pwm_o,
  output logic [NPH-1:0] pwm_oe,
  output logic cooling_request_o,
  output logic cooling_request_oe,
  output logic overtemp_alert_o,
  output logic overtemp_alert_oe,
  output logic soft_start_req,
  output logic [5:0] temp_code,
  output logic [3:0] thermal_offset_input_factor,
  output logic [11:0] comp_gain
);
  ots_state_t state_q, state_d;
  logic ctrl_run_q;
  logic en;
  logic fault;
  logic retry_due;
  logic ss_d;
  logic [12:0] wait_cnt_q;
  logic [15:0] trip_cnt_q;
  logic [NPH-1:0] blank_q;
  logic aw_hold_q, w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_go;
  logic wr_mapped;
  logic [31:0] rd_word;
  logic rd_mapped;
  logic [13:0] factor_prod;
  logic [7:0] temp_adj;
  logic [9:0] tm_inv;
  logic cool_low_q, hot_low_q;

  assign en = ctrl_enable & ctrl_run_q;
  assign fault = averaged_phase_current_ovr | load_current_monitor_pin_ovr;
  assign retry_due = (wait_cnt_q == HICCUP_CYCLES);

  // hiccup sequencer; per-phase cuts are deliberately not a trip source
  always_comb begin
    state_d = state_q;
    ss_d = 1'b0;
    case (state_q)
      ST_OFF: begin
        if (en) begin
          state_d = ST_RUN;
          ss_d = 1'b1;
        end
      end
      ST_RUN: begin
        if (!en) begin
          state_d = ST_OFF;
        end else if (fault) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!en) begin
          state_d = ST_OFF;
        end else if (retry_due) begin
          state_d = ST_RUN;
          ss_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_OFF;
      soft_start_req <= 1'b0;
    end else begin
      state_q <= state_d;
      soft_start_req <= ss_d;
    end
  end

  // counts switching cycles, not clocks; cleared on every fresh trip
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_cnt_q <= 13'h0000;
    end else if (state_q != ST_WAIT || state_d != ST_WAIT) begin
      wait_cnt_q <= 13'h0000;
    end else if (cycle_start && !retry_due) begin
      wait_cnt_q <= wait_cnt_q + 13'h0001;
    end
  end

  // cut latches until a cycle start finds the phase back under its limit
  generate
    for (genvar i = 0; i < NPH; i++) begin : g_phase
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          blank_q[i] <= 1'b0;
        end else if (phase_oc_cmp[i]) begin
          blank_q[i] <= 1'b1;
        end else if (cycle_start) begin
          blank_q[i] <= 1'b0;
        end
      end
      // one clock of 40 ns is the fastest a registered pin can float
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pwm_oe[i] <= 1'b0;
          pwm_o[i] <= 1'b0;
        end else begin
          pwm_oe[i] <= (state_d == ST_RUN);
          pwm_o[i] <= (state_d == ST_RUN) && pwm_req[i] &&
                      !phase_oc_cmp[i] && !(blank_q[i] && !cycle_start);
        end
      end
    end
  endgenerate

  ots_hyst_flag u_cool (
    .aclk(aclk),
    .aresetn(aresetn),
    .valid(en),
    .level(thermistor_sense_input),
    .pull_th(TM_FAN_PULL),
    .release_th(TM_FAN_RELEASE),
    .drive_low_q(cool_low_q)
  );

  ots_hyst_flag u_hot (
    .aclk(aclk),
    .aresetn(aresetn),
    .valid(en),
    .level(thermistor_sense_input),
    .pull_th(TM_HOT_PULL),
    .release_th(TM_HOT_RELEASE),
    .drive_low_q(hot_low_q)
  );

  // pin data stays low; only the enable moves an open-drain pin
  assign cooling_request_o = 1'b0;
  assign overtemp_alert_o = 1'b0;
  assign cooling_request_oe = cool_low_q;
  assign overtemp_alert_oe = hot_low_q;

  // crude linear conversion; real parts shape this with a nonlinear converter
  assign tm_inv = 10'h3ff - thermistor_sense_input;
  assign factor_prod = thermal_offset_input * THERMAL_OFFSET_INPUT_FACTOR_MULT;
  // factor below 4 lowers the assumed sense temperature, above 4 raises it
  assign temp_adj = ({2'b00, temp_code} + {4'h0, thermal_offset_input_factor} >= {4'h0, THERMAL_OFFSET_INPUT_ZERO_DELTA}) ?
                    ({2'b00, temp_code} + {4'h0, thermal_offset_input_factor} - {4'h0, THERMAL_OFFSET_INPUT_ZERO_DELTA}) :
                    8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temp_code <= 6'h00;
      thermal_offset_input_factor <= 4'h0;
      comp_gain <= GAIN_UNITY;
    end else begin
      temp_code <= tm_inv[9:4];
      thermal_offset_input_factor <= factor_prod[13:10];
      if (thermal_offset_input_factor == 4'h0) begin
        comp_gain <= GAIN_UNITY;
      end else begin
        comp_gain <= GAIN_UNITY - {2'b00, temp_adj, 2'b00};
      end
    end
  end

  // write channel: address and data captured in either order
  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_mapped = (aw_addr_q[7:2] == ADDR_CTRL[7:2]) ||
                     (aw_addr_q[7:2] == ADDR_STATUS[7:2]) ||
                     (aw_addr_q[7:2] == ADDR_THERM[7:2]) ||
                     (aw_addr_q[7:2] == ADDR_TRIP_CNT[7:2]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_run_q <= CTRL_RUN_RESET;
    end else if (wr_go && aw_addr_q[7:2] == ADDR_CTRL[7:2] && w_strb_q[0]) begin
      ctrl_run_q <= w_data_q[CTRL_RUN_BIT];
    end
  end

  // a trip in the same cycle as a clearing write still counts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trip_cnt_q <= 16'h0000;
    end else if (state_q == ST_RUN && state_d == ST_WAIT) begin
      if (wr_go && aw_addr_q[7:2] == ADDR_TRIP_CNT[7:2]) begin
        trip_cnt_q <= 16'h0001;
      end else begin
        trip_cnt_q <= trip_cnt_q + 16'h0001;
      end
    end else if (wr_go && aw_addr_q[7:2] == ADDR_TRIP_CNT[7:2]) begin
      trip_cnt_q <= 16'h0000;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (s_axi_araddr[7:2])
      ADDR_CTRL[7:2]: rd_word[CTRL_RUN_BIT] = ctrl_run_q;
      ADDR_STATUS[7:2]: begin
        rd_word[STS_STATE_LSB +: 2] = state_q;
        rd_word[STS_AVG_OC_BIT] = averaged_phase_current_ovr;
        rd_word[STS_MON_OC_BIT] = load_current_monitor_pin_ovr;
        rd_word[STS_COOL_BIT] = !cool_low_q;
        rd_word[STS_HOT_BIT] = !hot_low_q;
        rd_word[STS_EN_BIT] = en;
        rd_word[STS_BLANK_LSB +: NPH] = blank_q;
      end
      ADDR_THERM[7:2]: begin
        rd_word[THERM_TEMP_LSB +: 6] = temp_code;
        rd_word[THERM_FACTOR_LSB +: 4] = thermal_offset_input_factor;
        rd_word[THERM_GAIN_LSB +: 12] = comp_gain;
      end
      ADDR_TRIP_CNT[7:2]: rd_word[15:0] = trip_cnt_q;
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  AST_AVG_TRIP: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_RUN && en && averaged_phase_current_ovr |=> state_q == ST_WAIT)
    else $error("average overcurrent did not trip");
  AST_MON_TRIP: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_RUN && en && load_current_monitor_pin_ovr |=> state_q == ST_WAIT)
    else $error("monitor pin overcurrent did not trip");
  AST_HIZ_FAST: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_RUN && en && fault |=> pwm_oe == '0)
    else $error("PWM outputs not floated on trip");
  AST_WAIT_FLOAT: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state_q == ST_WAIT) |-> pwm_oe == '0 && wait_cnt_q == 13'h0000)
    else $error("wait entered with outputs driven or stale count");
  AST_WAIT_BOUND: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_WAIT && !retry_due |=> state_q != ST_RUN)
    else $error("retry before wait period ended");
  AST_RETRY: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_WAIT && retry_due && en |=> state_q == ST_RUN && soft_start_req && pwm_oe != '0)
    else $error("no soft-start at end of wait");
  AST_DISABLE: assert property (@(posedge aclk) disable iff (!aresetn)
    !en |=> state_q == ST_OFF && pwm_oe == '0 && wait_cnt_q == 13'h0000)
    else $error("disable left outputs or count active");
  AST_PHASE_CUT: assert property (@(posedge aclk) disable iff (!aresetn)
    phase_oc_cmp[0] |=> !pwm_o[0] && blank_q[0])
    else $error("phase 0 not cut on overcurrent");
  AST_PHASE_REARM: assert property (@(posedge aclk) disable iff (!aresetn)
    blank_q[0] && cycle_start && !phase_oc_cmp[0] |=> !blank_q[0])
    else $error("phase 0 not re-armed on new cycle");
  AST_PHASE_NO_TRIP: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_RUN && en && !fault && phase_oc_cmp != '0 |=> state_q == ST_RUN)
    else $error("phase limit caused shutdown");
  AST_FLAG_DIS: assert property (@(posedge aclk) disable iff (!aresetn)
    !en |=> cooling_request_oe && overtemp_alert_oe)
    else $error("thermal flag released while disabled");
  AST_GAIN_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    thermal_offset_input_factor == 4'h0 |=> comp_gain == GAIN_UNITY)
    else $error("compensation active with zero factor");

  COV_TRIP: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_RUN ##1 state_q == ST_WAIT);
  COV_RETRY: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_WAIT ##1 state_q == ST_RUN);
  COV_CUT: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == ST_RUN && phase_oc_cmp[0] ##1 blank_q[0] && cycle_start);
  COV_HOT: cover property (@(posedge aclk) disable iff (!aresetn)
    en && !overtemp_alert_oe);
endmodule // ots_supervisor
